// ===== src/saf_regs.sv
// Engine-side registers: endpoint control, frame count, local and first alternate address.
// Assumes token and end-of-transaction signals come from the serial interface engine.
//
// Functional notes
// - Each virtual endpoint has its own control register, chosen by token endpoint.
// - Control writes always accepted; applied only after endpoint's transaction ends.
// - Several writes during one transaction: only the last value is applied.
// - 11-bit frame number captured on end-of-transaction rise for accepted SOF.
// - Frame count keeps last good SOF number; corrupt SOF leaves it alone.
// - Frame count increments itself on a missing SOF or frame number error.
// - SOF missing when later than previous interval plus three bit clocks.
// - High frame bits 7..3 hold extended bits, loaded only when enabled.
// - Receive-all bit skips address compare and CRC, every token except SOF accepted.
// - Local address bits 6..0 are the enumerated address for all endpoints.
// - Alternate one enabled opens endpoints 4 to 7, else no effect.
// - Alternate one bits 6..0 hold the seven-bit address compared against.
// - Receive field: none, stall, ack/nak by readiness, always nak.
// - Transmit field: none, stall, ack/nak by queue contents, always nak.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module saf_regs (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic tok_valid_in,
  input wire logic [6:0] tok_addr_in,
  input wire logic [3:0] tok_ep_in,
  input wire logic tok_crc_ok_in,
  input wire logic tok_sof_in,
  input wire logic end_of_transaction_in,
  input wire logic ack_in,
  input wire logic [15:0] sof_frame_in,
  input wire logic sof_frame_err_in,
  input wire logic rx_ready_in,
  input wire logic tx_queue_ready_in,
  output logic endpoint_match_out,
  output logic receive_all_out,
  output logic [7:0] endpoint_control_out,
  output logic [1:0] rx_resp_out,
  output logic [1:0] tx_resp_out
);

  typedef struct packed {
    saf_pkg::saf_xact_t xact;
    logic [3:0] cur_ep;
    logic cur_sof;
    logic cur_crc_ok;
    logic eot_prev;
    logic [15:0] frame;
    logic [7:0] local_addr;
    logic [7:0] alt_one;
    logic [7:0] engine_cfg;
    logic match;
    logic [1:0] rx_resp;
    logic [1:0] tx_resp;
  } saf_state_t;

  saf_state_t st_r;
  saf_state_t st_nxt;

  logic eot_rise;
  logic sof_good;
  logic sof_miss;
  logic fw_hit;
  logic [7:0] alt_rdata;
  logic [7:0] eng_ctrl;
  logic busy;

  // ==========================================================
  // Sub-blocks
  saf_endpoint_control_mem i_saf_endpoint_control_mem (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .fw_wr_in(reg_wr_in),
    .fw_rd_in(reg_rd_in),
    .fw_hit_in(fw_hit),
    .fw_idx_in(reg_addr_in[3:0]),
    .fw_wdata_in(reg_wdata_in),
    .fw_alt_rdata_in(alt_rdata),
    .fw_rdata_out(reg_rdata_out),
    .busy_in(busy),
    .busy_ep_in(st_r.cur_ep),
    .eng_ep_in(st_r.cur_ep),
    .eng_ctrl_out(eng_ctrl)
  );

  saf_sof_timer i_saf_sof_timer (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .sof_good_in(sof_good),
    .miss_out(sof_miss)
  );

  // ==========================================================
  // Firmware read mux for plain registers
  always_comb begin
    fw_hit = saf_pkg::ep_hit(reg_addr_in);
    case (reg_addr_in)
      saf_pkg::OFS_FRAME_LOW: alt_rdata = st_r.frame[saf_pkg::DATA_W-1:0];
      saf_pkg::OFS_FRAME_HIGH: alt_rdata = st_r.frame[saf_pkg::COUNT_W-1:saf_pkg::DATA_W];
      saf_pkg::OFS_LOCAL_ADDR: alt_rdata = st_r.local_addr;
      saf_pkg::OFS_ALT_ONE: alt_rdata = st_r.alt_one;
      saf_pkg::OFS_ENGINE_CFG: alt_rdata = st_r.engine_cfg;
      default: alt_rdata = saf_pkg::RST_BYTE;
    endcase
  end

  // ==========================================================
  // Event decode
  always_comb begin
    busy = (st_r.xact == saf_pkg::XS_BUSY);
    eot_rise = end_of_transaction_in && !st_r.eot_prev;
    sof_good = eot_rise && busy && st_r.cur_sof && st_r.cur_crc_ok && ack_in;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic rx_all;
    logic local_hit;
    logic alt_hit;
    logic ext_en;
    rx_all = 1'b0;
    local_hit = 1'b0;
    alt_hit = 1'b0;
    ext_en = 1'b0;
    st_nxt = st_r;
    st_nxt.eot_prev = end_of_transaction_in;
    rx_all = st_r.local_addr[saf_pkg::ADDR_ENABLE_BIT];
    ext_en = st_r.engine_cfg[saf_pkg::CFG_EXT_BIT];

    // Firmware writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        saf_pkg::OFS_LOCAL_ADDR: st_nxt.local_addr = reg_wdata_in;
        saf_pkg::OFS_ALT_ONE: st_nxt.alt_one = reg_wdata_in;
        saf_pkg::OFS_ENGINE_CFG: st_nxt.engine_cfg = reg_wdata_in;
        default: st_nxt.engine_cfg = st_r.engine_cfg;
      endcase
    end

    // Transaction tracking and address filter
    case (st_r.xact)
      saf_pkg::XS_IDLE: begin
        st_nxt.xact = saf_pkg::XS_IDLE;
      end
      saf_pkg::XS_BUSY: begin
        if (eot_rise) begin
          st_nxt.xact = saf_pkg::XS_IDLE;
        end
      end
      default: begin
        st_nxt.xact = saf_pkg::XS_IDLE;
      end
    endcase
    if (tok_valid_in) begin
      local_hit = (tok_addr_in == st_r.local_addr[saf_pkg::DEV_ADDR_W-1:0]);
      alt_hit = st_r.alt_one[saf_pkg::ADDR_ENABLE_BIT]
        && (tok_addr_in == st_r.alt_one[saf_pkg::DEV_ADDR_W-1:0])
        && (tok_ep_in >= saf_pkg::ALT_ONE_EP_FIRST)
        && (tok_ep_in <= saf_pkg::ALT_ONE_EP_LAST);
      st_nxt.xact = saf_pkg::XS_BUSY;
      st_nxt.cur_ep = tok_ep_in;
      st_nxt.cur_sof = tok_sof_in;
      st_nxt.cur_crc_ok = tok_crc_ok_in;
      if (rx_all) begin
        st_nxt.match = !tok_sof_in;
      end else begin
        st_nxt.match = !tok_sof_in && tok_crc_ok_in && (local_hit || alt_hit);
      end
    end else if (eot_rise) begin
      st_nxt.match = 1'b0;
    end

    // Handshake answers from the applied endpoint control
    st_nxt.rx_resp = saf_pkg::hs_resp(saf_pkg::rx_field(eng_ctrl), rx_ready_in);
    st_nxt.tx_resp = saf_pkg::hs_resp(saf_pkg::tx_field(eng_ctrl), tx_queue_ready_in);

    // Frame count
    if (sof_good && !sof_frame_err_in) begin
      st_nxt.frame[saf_pkg::FRAME_W-1:0] = sof_frame_in[saf_pkg::FRAME_W-1:0];
      if (ext_en) begin
        st_nxt.frame[saf_pkg::COUNT_W-1:saf_pkg::FRAME_W] =
          sof_frame_in[saf_pkg::COUNT_W-1:saf_pkg::FRAME_W];
      end
    end else if ((sof_good && sof_frame_err_in) || sof_miss) begin
      st_nxt.frame = st_r.frame + saf_pkg::COUNT_STEP;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign endpoint_match_out = st_r.match;
  assign receive_all_out = st_r.local_addr[saf_pkg::ADDR_ENABLE_BIT];
  assign endpoint_control_out = eng_ctrl;
  assign rx_resp_out = st_r.rx_resp;
  assign tx_resp_out = st_r.tx_resp;

endmodule : saf_regs

// ===== src/saf_pkg.sv
// Shared constants, types and helpers of the address, frame and endpoint register block.
// Assumes byte-wide firmware register port and 16 virtual endpoints.
package saf_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned EP_NUM = 16;
  localparam int unsigned EP_W = 4;
  localparam int unsigned DEV_ADDR_W = 7;
  localparam int unsigned FRAME_W = 11;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned TIMER_W = 20;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] OFS_ENDPOINT_CONTROL_BASE = 16'h7f80;
  localparam logic [15:0] OFS_FRAME_LOW = 16'h7f90;
  localparam logic [15:0] OFS_FRAME_HIGH = 16'h7f91;
  localparam logic [15:0] OFS_LOCAL_ADDR = 16'h7f92;
  localparam logic [15:0] OFS_ALT_ONE = 16'h7f99;
  localparam logic [15:0] OFS_ENGINE_CFG = 16'h7f9a;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam int unsigned ADDR_ENABLE_BIT = 7;
  localparam int unsigned CFG_EXT_BIT = 0;
  localparam int unsigned TXC_HI_BIT = 5;
  localparam int unsigned TXC_LO_BIT = 3;
  localparam int unsigned RXC_HI_BIT = 4;
  localparam int unsigned RXC_LO_BIT = 2;
  localparam logic [3:0] ALT_ONE_EP_FIRST = 4'h4;
  localparam logic [3:0] ALT_ONE_EP_LAST = 4'h7;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // ==========================================================
  // Timing, in bus bit clocks
  localparam logic [19:0] SOF_TOL_CYC = 20'h0_0003;
  localparam logic [19:0] TIMER_STEP = 20'h0_0001;
  localparam logic [19:0] TIMER_ZERO = 20'h0_0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_STALL = 2'b01,
    HS_READY = 2'b10,
    HS_NAK = 2'b11
  } saf_hs_field_t;

  typedef enum logic [1:0] {
    RESP_NONE = 2'b00,
    RESP_STALL = 2'b01,
    RESP_ACK = 2'b11,
    RESP_NAK = 2'b10
  } saf_resp_t;

  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_BUSY = 2'b01
  } saf_xact_t;

  // ==========================================================
  // Helpers
  function automatic saf_hs_field_t rx_field(input logic [7:0] ctrl);
    rx_field = saf_hs_field_t'({ctrl[RXC_HI_BIT], ctrl[RXC_LO_BIT]});
  endfunction : rx_field

  function automatic saf_hs_field_t tx_field(input logic [7:0] ctrl);
    tx_field = saf_hs_field_t'({ctrl[TXC_HI_BIT], ctrl[TXC_LO_BIT]});
  endfunction : tx_field

  function automatic saf_resp_t hs_resp(input saf_hs_field_t f, input logic ready);
    case (f)
      HS_STALL: hs_resp = RESP_STALL;
      HS_READY: hs_resp = ready ? RESP_ACK : RESP_NAK;
      HS_NAK: hs_resp = RESP_NAK;
      default: hs_resp = RESP_NONE;
    endcase
  endfunction : hs_resp

  function automatic logic ep_hit(input logic [15:0] a);
    ep_hit = (a[15:4] == OFS_ENDPOINT_CONTROL_BASE[15:4]);
  endfunction : ep_hit

endpackage : saf_pkg

// ===== src/saf_sof_timer.sv
// Measures the interval between good start-of-frame tokens and flags a missing one.
// Assumes the clock is the bus bit clock and sof_good_in is a one-cycle pulse.
`timescale 1ns/1ps
module saf_sof_timer (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic sof_good_in,
  output logic miss_out
);

  typedef struct packed {
    logic [19:0] cnt;
    logic [19:0] expect_len;
    logic known;
    logic seen;
    logic skip;
    logic miss;
  } saf_timer_t;

  saf_timer_t st_r;
  saf_timer_t st_nxt;

  // ==========================================================
  // Interval tracking
  always_comb begin
    st_nxt = st_r;
    st_nxt.miss = 1'b0;
    st_nxt.cnt = st_r.cnt + saf_pkg::TIMER_STEP;
    if (sof_good_in) begin
      st_nxt.cnt = saf_pkg::TIMER_ZERO;
      st_nxt.skip = 1'b0;
      st_nxt.seen = 1'b1;
      if (st_r.seen && !st_r.skip) begin
        st_nxt.expect_len = st_r.cnt;
        st_nxt.known = 1'b1;
      end
    end else if (st_r.known && st_r.cnt == st_r.expect_len + saf_pkg::SOF_TOL_CYC) begin
      st_nxt.miss = 1'b1;
      st_nxt.cnt = saf_pkg::SOF_TOL_CYC;
      st_nxt.skip = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign miss_out = st_r.miss;

endmodule : saf_sof_timer

// ===== src/saf_endpoint_control_mem.sv
// Endpoint control store: firmware copy and engine copy for each virtual endpoint.
// Assumes busy_in marks the transaction in progress on endpoint busy_ep_in.
`timescale 1ns/1ps
module saf_endpoint_control_mem (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic fw_wr_in,
  input wire logic fw_rd_in,
  input wire logic fw_hit_in,
  input wire logic [3:0] fw_idx_in,
  input wire logic [7:0] fw_wdata_in,
  input wire logic [7:0] fw_alt_rdata_in,
  output logic [7:0] fw_rdata_out,
  input wire logic busy_in,
  input wire logic [3:0] busy_ep_in,
  input wire logic [3:0] eng_ep_in,
  output logic [7:0] eng_ctrl_out
);

  typedef struct packed {
    logic [15:0][7:0] pend;
    logic [15:0][7:0] act;
    logic [15:0] dirty;
    logic [7:0] fw_rdata;
    logic [7:0] eng_ctrl;
  } saf_mem_t;

  saf_mem_t st_r;
  saf_mem_t st_nxt;

  // ==========================================================
  // Deferred apply and access ports
  always_comb begin
    st_nxt = st_r;
    st_nxt.fw_rdata = saf_pkg::RST_BYTE;
    for (int i = 0; i < int'(saf_pkg::EP_NUM); i++) begin
      if (st_r.dirty[i] && !(busy_in && busy_ep_in == 4'(i))) begin
        st_nxt.act[i] = st_r.pend[i];
        st_nxt.dirty[i] = 1'b0;
      end
    end
    if (fw_wr_in && fw_hit_in) begin
      st_nxt.pend[fw_idx_in] = fw_wdata_in;
      st_nxt.dirty[fw_idx_in] = 1'b1;
    end
    if (fw_rd_in) begin
      st_nxt.fw_rdata = fw_hit_in ? st_r.pend[fw_idx_in] : fw_alt_rdata_in;
    end
    st_nxt.eng_ctrl = st_r.act[eng_ep_in];
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fw_rdata_out = st_r.fw_rdata;
  assign eng_ctrl_out = st_r.eng_ctrl;

endmodule : saf_endpoint_control_mem

// ===== dv/saf_regs_monitor.sv
// Port checker of the register block.
// Assumes bind onto saf_regs, with saf_pkg compiled first.
`timescale 1ns/1ps
module saf_regs_monitor (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic tok_valid_in,
  input wire logic tok_crc_ok_in,
  input wire logic tok_sof_in,
  input wire logic end_of_transaction_in,
  input wire logic endpoint_match_out,
  input wire logic receive_all_out,
  input wire logic [7:0] endpoint_control_out,
  input wire logic [1:0] rx_resp_out,
  input wire logic [1:0] tx_resp_out
);
  // ==========
  // Assertions
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  a_all_follow: assert property (reg_wr_in && reg_addr_in == saf_pkg::OFS_LOCAL_ADDR
    |-> ##2 receive_all_out == $past(reg_wdata_in[7], 2)) else $error("receive-all bit wrong");
  a_sof_no_match: assert property (tok_valid_in && tok_sof_in
    |=> !endpoint_match_out) else $error("start-of-frame token matched");
  a_crc_gate: assert property (tok_valid_in && !tok_crc_ok_in && !receive_all_out
    |=> !endpoint_match_out) else $error("bad token check value matched");
  a_match_cause: assert property ($rose(endpoint_match_out)
    |-> $past(tok_valid_in)) else $error("match without token");
  a_match_drop: assert property ($rose(end_of_transaction_in) && !tok_valid_in
    |-> ##2 !endpoint_match_out) else $error("match held after transaction");
  a_rx_stall_ans: assert property ($past(endpoint_control_out[4:2]) ==? 3'b0?1
    |-> rx_resp_out == 2'b01) else $error("receive stall answer wrong");
  a_rx_off_quiet: assert property ($past(endpoint_control_out[4:2]) ==? 3'b0?0
    |-> rx_resp_out == 2'b00) else $error("disabled receive answered");
  a_tx_nak_ans: assert property ($past(endpoint_control_out[5:3]) ==? 3'b1?1
    |-> tx_resp_out == 2'b10) else $error("transmit nak answer wrong");
endmodule : saf_regs_monitor

bind saf_regs saf_regs_monitor i_saf_regs_monitor (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .tok_valid_in(tok_valid_in),
  .tok_crc_ok_in(tok_crc_ok_in),
  .tok_sof_in(tok_sof_in),
  .end_of_transaction_in(end_of_transaction_in),
  .endpoint_match_out(endpoint_match_out),
  .receive_all_out(receive_all_out),
  .endpoint_control_out(endpoint_control_out),
  .rx_resp_out(rx_resp_out),
  .tx_resp_out(tx_resp_out)
);

// ===== dv/saf_host_model.sv
// Bus host model: decoded tokens and transaction ends.
// Assumes the bench calls its tasks; released fields show inverted values.
`timescale 1ns/1ps
module saf_host_model (
  input wire logic ref_clk_in,
  output logic tok_valid_out = 1'b0,
  output logic [6:0] tok_addr_out = 7'h00,
  output logic [3:0] tok_ep_out = 4'h0,
  output logic tok_crc_out = 1'b0,
  output logic tok_sof_out = 1'b0,
  output logic eot_out = 1'b0,
  output logic ack_out = 1'b0,
  output logic [15:0] frame_out = 16'h0000,
  output logic frame_err_out = 1'b0
);
  // ==========
  // Token and end of transaction
  task automatic send_token(input logic [6:0] a, input logic [3:0] e, input logic c,
                            input logic s);
    @(posedge ref_clk_in);
    tok_valid_out <= 1'b1;
    tok_addr_out <= a;
    tok_ep_out <= e;
    tok_crc_out <= c;
    tok_sof_out <= s;
    @(posedge ref_clk_in);
    tok_valid_out <= 1'b0;
    tok_addr_out <= ~a;
    tok_ep_out <= ~e;
    tok_crc_out <= ~c;
    tok_sof_out <= ~s;
  endtask : send_token

  task automatic end_xact(input logic k, input logic [15:0] f, input logic r);
    @(posedge ref_clk_in);
    eot_out <= 1'b1;
    ack_out <= k;
    frame_out <= f;
    frame_err_out <= r;
    @(posedge ref_clk_in);
    eot_out <= 1'b0;
    ack_out <= ~k;
    frame_out <= ~f;
    frame_err_out <= ~r;
  endtask : end_xact
endmodule : saf_host_model

// ===== dv/tb_saf_regs.sv
// Self-checking bench of the register block.
// Assumes the checker binds itself and the host model drives the token side.
`timescale 1ns/1ps
module tb_saf_regs;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic tx_queue_ready_in = 1'b0;
  logic [7:0] rdata, ctrl;
  logic [1:0] rx_resp, tx_resp;
  logic match, rx_all, tv, tc, ts, end_of_transaction, ack, ferr;
  logic [6:0] ta;
  logic [3:0] te;
  logic [15:0] frame;
  int fail_count = 0;
  int cmp_count = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  saf_host_model i_saf_host_model (.ref_clk_in(ref_clk_in), .tok_valid_out(tv),
    .tok_addr_out(ta), .tok_ep_out(te), .tok_crc_out(tc), .tok_sof_out(ts), .eot_out(end_of_transaction),
    .ack_out(ack), .frame_out(frame), .frame_err_out(ferr));

  saf_regs i_saf_regs (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .tok_valid_in(tv), .tok_addr_in(ta), .tok_ep_in(te),
    .tok_crc_ok_in(tc), .tok_sof_in(ts), .end_of_transaction_in(end_of_transaction), .ack_in(ack),
    .sof_frame_in(frame), .sof_frame_err_in(ferr), .rx_ready_in(rx_ready_in),
    .tx_queue_ready_in(tx_queue_ready_in), .endpoint_match_out(match),
    .receive_all_out(rx_all), .endpoint_control_out(ctrl), .rx_resp_out(rx_resp),
    .tx_resp_out(tx_resp));

  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("reg_rdata_out", e, rdata);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic do_reset;
    @(posedge ref_clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
  endtask : do_reset

  task automatic sof(input logic [15:0] f, input logic k, input logic r);
    i_saf_host_model.send_token(7'h00, 4'h0, 1'b1, 1'b1);
    i_saf_host_model.end_xact(k, f, r);
  endtask : sof

  task automatic tok_chk(input logic [6:0] a, input logic [3:0] e, input logic c, input logic x);
    i_saf_host_model.send_token(a, e, c, 1'b0);
    settle(1);
    chk("endpoint_match_out", 8'(x), 8'(match));
    i_saf_host_model.end_xact(1'b0, 16'h0000, 1'b0);
  endtask : tok_chk

  // ==========
  // Scenarios
  task automatic t_reset_vals;
    logic [15:0] ofs [6] = '{16'h7f90, 16'h7f91, 16'h7f92, 16'h7f99, 16'h7f9a, 16'h7fa0};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
  endtask : t_reset_vals

  task automatic t_match;
    logic [12:0] tab [8] = '{{1'b1, 1'b1, 4'h2, 7'h15}, {1'b0, 1'b1, 4'h2, 7'h16},
      {1'b0, 1'b0, 4'h2, 7'h15}, {1'b1, 1'b1, 4'h4, 7'h22}, {1'b1, 1'b1, 4'h7, 7'h22},
      {1'b0, 1'b1, 4'h3, 7'h22}, {1'b0, 1'b1, 4'h8, 7'h22}, {1'b1, 1'b1, 4'hf, 7'h15}};
    wr(16'h7f92, 8'h15);
    wr(16'h7f99, 8'ha2);
    rd(16'h7f99, 8'ha2);
    foreach (tab[i]) tok_chk(tab[i][6:0], tab[i][10:7], tab[i][11], tab[i][12]);
    wr(16'h7f99, 8'h22);
    tok_chk(7'h22, 4'h5, 1'b1, 1'b0);
  endtask : t_match

  task automatic t_rx_all;
    wr(16'h7f92, 8'h95);
    settle(2);
    chk("receive_all_out", 8'h01, 8'(rx_all));
    tok_chk(7'h40, 4'h2, 1'b0, 1'b1);
    wr(16'h7f92, 8'h15);
  endtask : t_rx_all

  task automatic t_endpoint_control;
    rx_ready_in <= 1'b1;
    tx_queue_ready_in <= 1'b1;
    wr(16'h7f85, 8'h08);
    i_saf_host_model.send_token(7'h15, 4'h5, 1'b1, 1'b0);
    i_saf_host_model.end_xact(1'b0, 16'h0000, 1'b0);
    settle(3);
    chk("endpoint_control_out", 8'h08, ctrl);
    chk("tx_resp_out", 8'h01, 8'(tx_resp));
    i_saf_host_model.send_token(7'h15, 4'h3, 1'b1, 1'b0);
    wr(16'h7f83, 8'h10);
    wr(16'h7f83, 8'h14);
    settle(3);
    chk("endpoint_control_out", 8'h00, ctrl);
    rd(16'h7f83, 8'h14);
    i_saf_host_model.end_xact(1'b0, 16'h0000, 1'b0);
    settle(3);
    chk("endpoint_control_out", 8'h14, ctrl);
    chk("rx_resp_out", 8'h02, 8'(rx_resp));
    wr(16'h7f83, 8'h30);
    settle(4);
    chk("rx_resp_out", 8'h03, 8'(rx_resp));
    chk("tx_resp_out", 8'h03, 8'(tx_resp));
    @(posedge ref_clk_in);
    rx_ready_in <= 1'b0;
    tx_queue_ready_in <= 1'b0;
    settle(2);
    chk("rx_resp_out", 8'h02, 8'(rx_resp));
    chk("tx_resp_out", 8'h02, 8'(tx_resp));
    wr(16'h7f83, 8'h28);
    settle(4);
    chk("rx_resp_out", 8'h00, 8'(rx_resp));
    chk("tx_resp_out", 8'h02, 8'(tx_resp));
    wr(16'h7f83, 8'h04);
    settle(4);
    chk("rx_resp_out", 8'h01, 8'(rx_resp));
  endtask : t_endpoint_control

  task automatic t_frame;
    do_reset();
    sof(16'habcd, 1'b1, 1'b0);
    rd(16'h7f90, 8'hcd);
    rd(16'h7f91, 8'h03);
    wr(16'h7f90, 8'hff);
    sof(16'h1111, 1'b0, 1'b0);
    rd(16'h7f90, 8'hcd);
    sof(16'h2222, 1'b1, 1'b1);
    rd(16'h7f90, 8'hce);
    do_reset();
    wr(16'h7f9a, 8'h01);
    sof(16'habcd, 1'b1, 1'b0);
    rd(16'h7f91, 8'hab);
    do_reset();
    for (int i = 5; i < 8; i++) begin
      sof(16'(i), 1'b1, 1'b0);
      repeat (16) @(posedge ref_clk_in);
    end
    rd(16'h7f90, 8'h07);
    repeat (3) @(posedge ref_clk_in);
    rd(16'h7f90, 8'h07);
    rd(16'h7f90, 8'h08);
  endtask : t_frame

  // ==========
  // Run control
  task automatic report_and_stop;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    t_reset_vals();
    t_match();
    t_rx_all();
    t_endpoint_control();
    t_frame();
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    fail_count++;
    report_and_stop();
  end
endmodule : tb_saf_regs
